// ---- t1_interrupt_status_latches.v ----
// Purpose : read-to-clear interrupt and overflow latch registers, page 4
// Assumes : host read strobe is one cycle, synchronous to i_mclk
// Notes   : masks, counters and interrupt pin live elsewhere
//
// Notes on behaviour
// - framing error counter wrap sets bit 7
// - checksum error counter wrap sets bit 6
// - out-of-frame counter wrap sets bit 5
// - alignment change counter wrap sets bit 4
// - bipolar violation counter wrap sets bit 3
// - test error counter wrap sets bit 2
// - test multiframe counter wrap sets bit 1
// - multiframe unsync counter wrap sets bit 0
// - interrupt bits set only if unmasked, sticky bits regardless; read clears
// - data link controller A event sets bit 6
// - channel 24 controller event sets bit 5
// - loop code held 48 ms sets bit 4
// - one second flag rising sets bit 3
// - five second flag rising sets bit 2
// - new bit-oriented message sets bit 1
// - message accepted if seen 8 of 10
// - signalling change sets bit 0, optionally debounced
// - bit 7 of link register reads zero
// - sticky latch bit per counter wrap
// - latch register cleared after host read
`timescale 1ns/1ps
`default_nettype none
`include "t1_irq_regs.vh"

module t1_interrupt_status_latches #(
  parameter CW        = 8,
  parameter LOOP_HOLD = (`LOOP_HOLD_US * `CLK_MHZ)
) (
  // clock and reset
  input  wire          i_mclk,
  input  wire          i_rst,
  // host register port
  input  wire [7:0]    i_page,
  input  wire [7:0]    i_addr,
  input  wire          i_rd,
  output reg  [7:0]    o_rdata,
  // counter values
  input  wire [CW-1:0] i_frame_bit_err_cnt,
  input  wire [CW-1:0] i_checksum_err_cnt,
  input  wire [CW-1:0] i_out_of_frame_cnt,
  input  wire [CW-1:0] i_align_change_cnt,
  input  wire [CW-1:0] i_bipolar_viol_cnt,
  input  wire [CW-1:0] i_test_pattern_err_cnt,
  input  wire [CW-1:0] i_test_multiframe_cnt,
  input  wire [CW-1:0] i_multiframe_unsync_cnt,
  // masks, one bit per register bit, high means unmasked
  input  wire [7:0]    i_wrap_unmask,
  input  wire [7:0]    i_event_unmask,
  // event sources
  input  wire          i_datalink_ctrl_a_evt,
  input  wire          i_datalink_ctrl_b_evt,
  input  wire          i_loop_up_seen,
  input  wire          i_loop_down_seen,
  input  wire          i_one_second_flag,
  input  wire          i_five_second_flag,
  input  wire          i_fdl_bit,
  input  wire          i_fdl_bit_valid,
  input  wire [3:0]    i_sig_bits,
  input  wire          i_sig_valid,
  input  wire          i_debounce_enable,
  // status views
  output reg  [7:0]    o_counter_overflow_interrupts,
  output reg  [7:0]    o_link_and_event_interrupts,
  output reg  [7:0]    o_sticky_overflow_flags
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  wire [7:0]  wrap_evt;          // one pulse per counter wrap
  reg  [7:0]  cnt_irq_reg;       // counter wrap interrupt bits
  reg  [7:0]  evt_irq_reg;       // link and event interrupt bits
  reg  [7:0]  sticky_reg;        // sticky wrap latches
  reg  [7:0]  cnt_irq_next;
  reg  [7:0]  evt_irq_next;
  reg  [7:0]  sticky_next;
  reg  [7:0]  evt_pulse;         // raw link and event pulses
  reg         one_sec_reg;       // previous one second flag
  reg         five_sec_reg;      // previous five second flag
  reg  [31:0] loop_cnt_reg;      // loop code persistence count
  reg         loop_done_reg;     // persistence already reported
  reg  [15:0] fdl_shift_reg;     // serial data link history
  reg  [3:0]  bit_pos_reg;       // bit position in message slot
  reg  [5:0]  bom_hist_reg [0:`BOM_WIN-1]; // last message payloads
  reg  [`BOM_WIN-1:0] bom_ok_reg;          // slot held a message
  reg  [5:0]  bom_last_reg;      // last accepted message
  reg         bom_new;           // a new message was accepted
  reg  [3:0]  sig_prev_reg;      // last reported signalling
  reg  [3:0]  sig_cand_reg;      // candidate for debounce
  reg         sig_chg;           // signalling change event
  wire [15:0] fdl_word;
  wire        rd_cnt;
  wire        rd_evt;
  wire        rd_sticky;
  integer     k;                 // loop index, vote process only
  integer     j;                 // loop index, history reset and shift only
  integer     votes;             // slots agreeing with current payload

  // ****************************************************************
  // read decode and serial word view
  // ****************************************************************
  // the word as it will stand once the present bit is shifted in;
  // the vote looks at it before the shift register catches up
  // reads outside page 4 or at other addresses clear nothing
  assign fdl_word  = {fdl_shift_reg[14:0], i_fdl_bit};
  assign rd_cnt    = i_rd && (i_page == `PAGE_IRQ) &&
                     (i_addr == `ADDR_CNT_WRAP_IRQ);
  assign rd_evt    = i_rd && (i_page == `PAGE_IRQ) &&
                     (i_addr == `ADDR_LINK_EVT_IRQ);
  assign rd_sticky = i_rd && (i_page == `PAGE_IRQ) &&
                     (i_addr == `ADDR_STICKY_WRAP);

  // ****************************************************************
  // counter wrap detectors, bit 7 down to bit 0
  // ****************************************************************
  t1_wrap_detect #(.W(CW)) u_wrap7 (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_count(i_frame_bit_err_cnt), .o_wrap(wrap_evt[7]));
  t1_wrap_detect #(.W(CW)) u_wrap6 (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_count(i_checksum_err_cnt), .o_wrap(wrap_evt[6]));
  t1_wrap_detect #(.W(CW)) u_wrap5 (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_count(i_out_of_frame_cnt), .o_wrap(wrap_evt[5]));
  t1_wrap_detect #(.W(CW)) u_wrap4 (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_count(i_align_change_cnt), .o_wrap(wrap_evt[4]));
  t1_wrap_detect #(.W(CW)) u_wrap3 (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_count(i_bipolar_viol_cnt), .o_wrap(wrap_evt[3]));
  t1_wrap_detect #(.W(CW)) u_wrap2 (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_count(i_test_pattern_err_cnt), .o_wrap(wrap_evt[2]));
  t1_wrap_detect #(.W(CW)) u_wrap1 (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_count(i_test_multiframe_cnt), .o_wrap(wrap_evt[1]));
  t1_wrap_detect #(.W(CW)) u_wrap0 (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_count(i_multiframe_unsync_cnt), .o_wrap(wrap_evt[0]));

  // ****************************************************************
  // loop code persistence: must be held the whole interval
  // ****************************************************************
  // either code counts; a gap of one cycle restarts the interval
  // the done flag stops a second report while the code stays up
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      loop_cnt_reg  <= 32'h00000000;
      loop_done_reg <= 1'b0;
    end else if (!(i_loop_up_seen || i_loop_down_seen)) begin
      // code gone, restart timing
      loop_cnt_reg  <= 32'h00000000;
      loop_done_reg <= 1'b0;
    end else if (loop_cnt_reg < LOOP_HOLD - 1) begin
      loop_cnt_reg  <= loop_cnt_reg + 32'h00000001;
    end else begin
      loop_done_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // bit-oriented message capture and 8 of 10 vote
  // ****************************************************************
  // slots are counted from reset, one every 16 valid bits; a link
  // that starts mid-word is only caught after realignment upstream
  // the vote reads the nine earlier slots of history, the present slot makes
  // the tenth, so a steady new message is taken on its eighth slot
  always @* begin
    votes = 0;
    for (k = 0; k < `BOM_WIN - 1; k = k + 1) begin
      if (bom_ok_reg[k] && bom_hist_reg[k] == fdl_word[6:1])
        votes = votes + 1;
    end
    // the message in the current slot counts too
    bom_new = i_fdl_bit_valid && (bit_pos_reg == 4'hF) &&
              ((fdl_word & `BOM_MASK) == `BOM_MATCH) &&
              (votes + 1 >= `BOM_VOTE) &&
              (fdl_word[6:1] != bom_last_reg);
  end

  // shift register, slot position and message history
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      fdl_shift_reg <= 16'h0000;
      bit_pos_reg   <= 4'h0;
      bom_ok_reg    <= {`BOM_WIN{1'b0}};
      bom_last_reg  <= 6'h00;
      for (j = 0; j < `BOM_WIN; j = j + 1)
        bom_hist_reg[j] <= 6'h00;
    end else if (i_fdl_bit_valid) begin
      fdl_shift_reg <= fdl_word;
      bit_pos_reg   <= bit_pos_reg + 4'h1;
      if (bit_pos_reg == 4'hF) begin
        // shift one message slot into history
        for (j = `BOM_WIN - 1; j > 0; j = j - 1)
          bom_hist_reg[j] <= bom_hist_reg[j-1];
        bom_hist_reg[0] <= fdl_word[6:1];
        bom_ok_reg <= {bom_ok_reg[`BOM_WIN-2:0],
                       ((fdl_word & `BOM_MASK) == `BOM_MATCH)};
        if (bom_new)
          bom_last_reg <= fdl_word[6:1];
      end
    end
  end

  // ****************************************************************
  // signalling change, debounced by two agreeing samples if enabled
  // ****************************************************************
  // without debounce every valid sample that differs is reported;
  // with it, a single corrupted sample is never reported
  always @* begin
    if (!i_sig_valid || i_sig_bits == sig_prev_reg)
      sig_chg = 1'b0;
    else if (i_debounce_enable)
      sig_chg = (i_sig_bits == sig_cand_reg);
    else
      sig_chg = 1'b1;
  end

  // signalling history and one-cycle delayed second flags
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sig_prev_reg <= 4'h0;
      sig_cand_reg <= 4'h0;
      one_sec_reg  <= 1'b0;
      five_sec_reg <= 1'b0;
    end else begin
      one_sec_reg  <= i_one_second_flag;
      five_sec_reg <= i_five_second_flag;
      if (i_sig_valid)
        sig_cand_reg <= i_sig_bits;
      if (sig_chg)
        sig_prev_reg <= i_sig_bits;
    end
  end

  // ****************************************************************
  // raw event vector for the link and event register
  // ****************************************************************
  always @* begin
    evt_pulse = 8'h00;
    evt_pulse[`BIT_DLINK_A]  = i_datalink_ctrl_a_evt;
    evt_pulse[`BIT_DLINK_B]  = i_datalink_ctrl_b_evt;
    evt_pulse[`BIT_LOOPCODE] = (i_loop_up_seen || i_loop_down_seen) &&
      !loop_done_reg && (loop_cnt_reg == LOOP_HOLD - 1);
    evt_pulse[`BIT_ONE_SEC]  = i_one_second_flag && !one_sec_reg;
    evt_pulse[`BIT_FIVE_SEC] = i_five_second_flag && !five_sec_reg;
    evt_pulse[`BIT_BIT_MSG]  = bom_new;
    evt_pulse[`BIT_SIG_CHG]  = sig_chg;
  end

  // ****************************************************************
  // read-to-clear status registers, set beats clear
  // ****************************************************************
  // an event in the cycle of the clearing read survives the read, so
  // the host sees it on its next read instead of losing it
  // the sticky latch ignores masks on purpose
  always @* begin
    cnt_irq_next = (rd_cnt ? `IRQ_RESET : cnt_irq_reg) |
                   (wrap_evt & i_wrap_unmask);
    evt_irq_next = ((rd_evt ? `IRQ_RESET : evt_irq_reg) |
                   (evt_pulse & i_event_unmask)) &
                   8'h7F;
    sticky_next  = (rd_sticky ? `IRQ_RESET : sticky_reg) |
                   wrap_evt;
  end

  // state registers, status views and read data
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt_irq_reg <= `IRQ_RESET;
      evt_irq_reg <= `IRQ_RESET;
      sticky_reg  <= `IRQ_RESET;
      o_rdata     <= 8'h00;
      o_counter_overflow_interrupts <= `IRQ_RESET;
      o_link_and_event_interrupts   <= `IRQ_RESET;
      o_sticky_overflow_flags       <= `IRQ_RESET;
    end else begin
      cnt_irq_reg <= cnt_irq_next;
      evt_irq_reg <= evt_irq_next;
      sticky_reg  <= sticky_next;
      o_counter_overflow_interrupts <= cnt_irq_next;
      o_link_and_event_interrupts   <= evt_irq_next;
      o_sticky_overflow_flags       <= sticky_next;
      // read data returns the value before clearing
      if (rd_cnt)
        o_rdata <= cnt_irq_reg;
      else if (rd_evt)
        o_rdata <= evt_irq_reg;
      else if (rd_sticky)
        o_rdata <= sticky_reg;
      else if (i_rd)
        o_rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// ---- t1_irq_regs.vh ----
// Purpose : register map and field layout of the T1 interrupt status block
// Assumes : page 4 addresses as seen on the parallel processor port
// Notes   : definitions only
`ifndef T1_IRQ_REGS_VH
`define T1_IRQ_REGS_VH

// ****************************************************************
// register addresses inside page 4
// ****************************************************************
`define PAGE_IRQ            8'h04
`define ADDR_CNT_WRAP_IRQ   8'h1D
`define ADDR_LINK_EVT_IRQ   8'h1E
`define ADDR_STICKY_WRAP    8'h1F

// ****************************************************************
// field positions in the link and event register
// ****************************************************************
`define BIT_DLINK_A         6
`define BIT_DLINK_B         5
`define BIT_LOOPCODE        4
`define BIT_ONE_SEC         3
`define BIT_FIVE_SEC        2
`define BIT_BIT_MSG         1
`define BIT_SIG_CHG         0

// ****************************************************************
// reset values and wrap detection values
// ****************************************************************
`define IRQ_RESET           8'h00
`define CNT_MAX             8'hFF
`define CNT_ZERO            8'h00

// ****************************************************************
// bit-oriented message pattern and acceptance vote
// ****************************************************************
`define BOM_MASK            16'hFF81
`define BOM_MATCH           16'hFF00
`define BOM_WIN             10
`define BOM_VOTE            8

// ****************************************************************
// loop code persistence in microseconds, and clock rate in MHz
// ****************************************************************
`define LOOP_HOLD_US        48000
`define CLK_MHZ             40

`endif

// ---- t1_wrap_detect.v ----
// Purpose : spots one counter wrapping from all ones to zero
// Assumes : counter value sampled on the system clock
// Notes   : one-cycle pulse per wrap
`timescale 1ns/1ps
`default_nettype none
`include "t1_irq_regs.vh"

module t1_wrap_detect #(
  parameter W = 8
) (
  // clock and reset
  input  wire         i_mclk,
  input  wire         i_rst,
  // counter value
  input  wire [W-1:0] i_count,
  // wrap pulse
  output reg          o_wrap
);

  reg [W-1:0] prev_reg;  // counter value one cycle ago

  // ****************************************************************
  // compare previous and present value
  // ****************************************************************
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      prev_reg <= {W{1'b0}};
      o_wrap   <= 1'b0;
    end else begin
      prev_reg <= i_count;
      // wrap is all ones followed by zero
      o_wrap   <= (prev_reg == {W{1'b1}}) && (i_count == {W{1'b0}});
    end
  end

endmodule
`default_nettype wire

// ---- t1_interrupt_status_latches_asserts.sv ----
// Purpose: port checks for the interrupt status latches
// Assumes: one clock, reset high, reads are one-cycle strobes
// Notes:   bound to the top module, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module t1_interrupt_status_latches_asserts #(
  parameter CW        = 8,
  parameter LOOP_HOLD = 20
) (
  // clock, reset and host port
  input wire          i_mclk,
  input wire          i_rst,
  input wire [7:0]    i_page,
  input wire [7:0]    i_addr,
  input wire          i_rd,
  input wire [7:0]    o_rdata,
  // event side
  input wire [CW-1:0] i_frame_bit_err_cnt,
  input wire [7:0]    i_wrap_unmask,
  input wire [7:0]    i_event_unmask,
  input wire          i_one_second_flag,
  input wire          i_five_second_flag,
  // status views
  input wire [7:0]    o_counter_overflow_interrupts,
  input wire [7:0]    o_link_and_event_interrupts,
  input wire [7:0]    o_sticky_overflow_flags
);
  // ****************************************************************
  // decoded reads
  // ****************************************************************
  wire       pg   = (i_page == 8'h04);
  wire       rd_a = i_rd && pg && (i_addr == 8'h1D);
  wire       rd_b = i_rd && pg && (i_addr == 8'h1E);
  wire       rd_c = i_rd && pg && (i_addr == 8'h1F);
  wire [7:0] ovf  = o_counter_overflow_interrupts;
  wire [7:0] evt  = o_link_and_event_interrupts;
  wire [7:0] stk  = o_sticky_overflow_flags;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // read data is the register as it stood at the read edge
  AST_RD_WRAP: assert property (rd_a |=> o_rdata == $past(ovf))
    else $error("wrap register read data differs");
  AST_RD_EVT: assert property (rd_b |=> o_rdata == $past(evt))
    else $error("event register read data differs");
  AST_RD_STK: assert property (rd_c |=> o_rdata == $past(stk))
    else $error("sticky register read data differs");
  AST_RD_NONE: assert property (i_rd && !(rd_a || rd_b || rd_c)
    |=> o_rdata == 8'h00) else $error("unmapped read not zero");
  // a sticky bit only drops after a read of its register
  AST_STK_HOLD: assert property ((|($past(stk) & ~stk)) |-> $past(rd_c))
    else $error("sticky bit dropped without read");
  AST_WRAP_STK: assert property ((&$past(i_frame_bit_err_cnt))
    && (i_frame_bit_err_cnt == 0) |-> ##[1:3] stk[7])
    else $error("sticky bit missing after wrap");
  AST_WRAP_IRQ: assert property ((&$past(i_frame_bit_err_cnt))
    && (i_frame_bit_err_cnt == 0) && i_wrap_unmask[7] |-> ##[1:3] ovf[7])
    else $error("wrap interrupt missing");
  // a masked counter wrap never raises its bit
  AST_MASKED: assert property (~|(ovf & ~$past(ovf) & ~$past(i_wrap_unmask)
    & ~$past(i_wrap_unmask, 2))) else $error("masked wrap bit rose");
  AST_ONE_SEC: assert property ($rose(i_one_second_flag) && i_event_unmask[3]
    |-> ##[1:2] evt[3]) else $error("one second bit missing");
  AST_FIVE_SEC: assert property ($rose(i_five_second_flag) && i_event_unmask[2]
    |-> ##[1:2] evt[2]) else $error("five second bit missing");
  AST_UNUSED7: assert property (evt[7] == 1'b0)
    else $error("unused bit set");
endmodule
bind t1_interrupt_status_latches t1_interrupt_status_latches_asserts #(
  .CW(CW), .LOOP_HOLD(LOOP_HOLD)) u_asserts (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_page(i_page), .i_addr(i_addr),
  .i_rd(i_rd), .o_rdata(o_rdata),
  .i_frame_bit_err_cnt(i_frame_bit_err_cnt), .i_wrap_unmask(i_wrap_unmask),
  .i_event_unmask(i_event_unmask), .i_one_second_flag(i_one_second_flag),
  .i_five_second_flag(i_five_second_flag),
  .o_counter_overflow_interrupts(o_counter_overflow_interrupts),
  .o_link_and_event_interrupts(o_link_and_event_interrupts),
  .o_sticky_overflow_flags(o_sticky_overflow_flags));
`default_nettype wire

// ---- t1_interrupt_status_latches_tb.sv ----
// Purpose: self-checking bench for the interrupt status latches
// Assumes: 40 MHz clock, page and address held with the read strobe
// Notes:   loop code hold shortened to LH cycles
`timescale 1ns/1ps
`default_nettype none
`include "t1_irq_regs.vh"
module t1_interrupt_status_latches_tb;
  localparam LH = 20;
  reg        i_mclk, i_rst, i_rd, facility_data_link, fdl_v, lp_up, lp_dn, sig_v, dbe;
  reg  [3:0] ev, sig;
  reg  [7:0] i_page, i_addr, wm, em, d, acc;
  reg  [7:0] cnt [0:7];
  reg [31:0] seed;
  integer    k, n, b, num_errors, comparisons;
  wire [7:0] rdata, ovf_v, evt_v, stk_v;
  t1_interrupt_status_latches #(.CW(8), .LOOP_HOLD(LH))
    u_t1_interrupt_status_latches (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_page(i_page), .i_addr(i_addr),
    .i_rd(i_rd), .o_rdata(rdata),
    .i_frame_bit_err_cnt(cnt[0]), .i_checksum_err_cnt(cnt[1]),
    .i_out_of_frame_cnt(cnt[2]), .i_align_change_cnt(cnt[3]),
    .i_bipolar_viol_cnt(cnt[4]), .i_test_pattern_err_cnt(cnt[5]),
    .i_test_multiframe_cnt(cnt[6]), .i_multiframe_unsync_cnt(cnt[7]),
    .i_wrap_unmask(wm), .i_event_unmask(em),
    .i_datalink_ctrl_a_evt(ev[0]), .i_datalink_ctrl_b_evt(ev[1]),
    .i_loop_up_seen(lp_up), .i_loop_down_seen(lp_dn),
    .i_one_second_flag(ev[2]), .i_five_second_flag(ev[3]),
    .i_fdl_bit(facility_data_link), .i_fdl_bit_valid(fdl_v), .i_sig_bits(sig),
    .i_sig_valid(sig_v), .i_debounce_enable(dbe),
    .o_counter_overflow_interrupts(ovf_v), .o_link_and_event_interrupts(evt_v),
    .o_sticky_overflow_flags(stk_v));
  // ****************************************************************
  // helpers
  // ****************************************************************
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // expected register value for one event at bit p under mask m
  function [7:0] hit(input integer p, input [7:0] m);
    hit = m[p] ? (8'h01 << p) : 8'h00;
  endfunction
  // ones, a zero, six payload bits, a closing zero
  function [15:0] bom(input [5:0] p);
    bom = {8'hFF, 1'b0, p, 1'b0};
  endfunction
  task tick(input integer c);
    repeat (c) @(posedge i_mclk);
  endtask
  task check(input [7:0] got, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // one read strobe; data stands from the read edge, taken one later
  task rd(input [7:0] a);
    begin
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      @(posedge i_mclk);
      d = rdata;
    end
  endtask
  task rdc(input [7:0] a, input [7:0] e);
    begin
      rd(a);
      check(d, e);
    end
  endtask
  task sig_tx(input [3:0] v, input integer c);
    begin
      sig <= v;
      sig_v <= 1'b1;
      tick(c);
      sig_v <= 1'b0;
      tick(4);
    end
  endtask
  // serial message, first bit sent is the leftmost
  task bom_tx(input [15:0] w);
    integer j;
    begin
      for (j = 15; j >= 0; j = j - 1) begin
        facility_data_link <= w[j];
        fdl_v <= 1'b1;
        tick(1);
      end
      fdl_v <= 1'b0;
      tick(4);
    end
  endtask
  task wrap_up;
    begin
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // ****************************************************************
  // clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  initial begin
    tick(20000);
    num_errors = num_errors + 1;
    wrap_up;
  end
  initial begin
    i_rst = 1'b1;
    {i_rd, facility_data_link, fdl_v, lp_up, lp_dn, sig_v, dbe} = 7'h00;
    {ev, sig, i_addr, wm} = 24'h0;
    i_page = `PAGE_IRQ;
    em = 8'hFF;
    seed = 32'd33396;
    num_errors = 0;
    comparisons = 0;
    for (k = 0; k < 8; k = k + 1)
      cnt[k] = 8'h00;
    tick(8);
    i_rst <= 1'b0;
    tick(2);
    rdc(`ADDR_CNT_WRAP_IRQ, `IRQ_RESET);
    rdc(`ADDR_LINK_EVT_IRQ, `IRQ_RESET);
    rdc(`ADDR_STICKY_WRAP, `IRQ_RESET);
    // each counter wraps once under a random mask
    for (k = 0; k < 8; k = k + 1) begin
      seed = xs(seed);
      wm <= (k == 0) ? (seed[7:0] | 8'h80) : seed[7:0];
      cnt[k] <= seed[15:8] & 8'hFE;
      tick(2);
      cnt[k] <= `CNT_MAX;
      tick(2);
      cnt[k] <= `CNT_ZERO;
      tick(5);
      check(ovf_v, hit(7 - k, wm));
      check(stk_v, 8'h80 >> k);
      i_page <= 8'h03;
      rdc(`ADDR_CNT_WRAP_IRQ, 8'h00);
      i_page <= `PAGE_IRQ;
      rdc(8'h1C, 8'h00);
      rdc(`ADDR_CNT_WRAP_IRQ, hit(7 - k, wm));
      rdc(`ADDR_STICKY_WRAP, 8'h80 >> k);
      rdc(`ADDR_CNT_WRAP_IRQ, 8'h00);
      rdc(`ADDR_STICKY_WRAP, 8'h00);
      check(ovf_v | stk_v, 8'h00);
    end
    // wrap lands while reads run back to back
    wm <= 8'hFF;
    cnt[1] <= `CNT_MAX;
    tick(2);
    cnt[1] <= `CNT_ZERO;
    acc = 8'h00;
    for (n = 0; n < 6; n = n + 1) begin
      rd(`ADDR_CNT_WRAP_IRQ);
      acc = acc | d;
    end
    check(acc, 8'h40);
    rdc(`ADDR_STICKY_WRAP, 8'h40);
    // link controllers and second flags, unmasked then random mask
    for (n = 0; n < 8; n = n + 1) begin
      seed = xs(seed);
      em <= (n < 4) ? 8'hFF : seed[7:0];
      b = (n % 4 < 2) ? 6 - n % 4 : 5 - n % 4;
      ev <= 4'h1 << (n % 4);
      tick(2);
      ev <= 4'h0;
      tick(4);
      check(evt_v, hit(b, em));
      rdc(`ADDR_LINK_EVT_IRQ, hit(b, em));
    end
    // loop up, loop down, then a hold that is too short
    em <= 8'hFF;
    for (n = 0; n < 3; n = n + 1) begin
      lp_up <= (n != 1);
      lp_dn <= (n == 1);
      tick((n == 2) ? LH - 3 : LH + 2);
      {lp_up, lp_dn} <= 2'b00;
      tick(3);
      rdc(`ADDR_LINK_EVT_IRQ, (n == 2) ? 8'h00 : 8'h10);
    end
    // signalling change, plain then debounced
    sig_tx(4'h5, 1);
    rdc(`ADDR_LINK_EVT_IRQ, 8'h01);
    dbe <= 1'b1;
    sig_tx(4'hA, 1);
    sig_tx(4'h5, 1);
    rdc(`ADDR_LINK_EVT_IRQ, 8'h00);
    sig_tx(4'hA, 2);
    rdc(`ADDR_LINK_EVT_IRQ, 8'h01);
    // a new message is taken on its eighth slot only
    seed = xs(seed);
    for (n = 0; n < 10; n = n + 1) begin
      bom_tx(bom(seed[5:0] | 6'h01));
      if (n == 6)
        rdc(`ADDR_LINK_EVT_IRQ, 8'h00);
      if (n == 7)
        rdc(`ADDR_LINK_EVT_IRQ, 8'h02);
    end
    rdc(`ADDR_LINK_EVT_IRQ, 8'h00);
    wrap_up;
  end
endmodule
`default_nettype wire
